// *** src/osc_div_pkg.sv ***
package osc_div_pkg;

  // ---------------------------------------------------------------------------
  // oscillator timing
  // ---------------------------------------------------------------------------
  localparam int OSC_NOMINAL_KHZ = 8000;
  localparam int OSC_MIN_KHZ     = 4000;
  localparam int OSC_MAX_KHZ     = 10000;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int CLK_RATE_KHZ    = 1000000 / CLK_PERIOD_NS;
  // half period of the modelled oscillator in system clock cycles (>= 1)
  localparam int OSC_HALF_CYCLES =
    (CLK_RATE_KHZ / (2 * OSC_NOMINAL_KHZ)) < 1 ? 1 :
    (CLK_RATE_KHZ / (2 * OSC_NOMINAL_KHZ));

  // ---------------------------------------------------------------------------
  // divider layout
  // ---------------------------------------------------------------------------
  localparam int DIV_WIDTH = 19;
  localparam int TAP_COUNT = 4;
  localparam int TAP_BIT0  = 4;
  localparam int TAP_BIT1  = 9;
  localparam int TAP_BIT2  = 14;
  localparam int TAP_BIT3  = 19;
  localparam logic [DIV_WIDTH-1:0] DIV_RESET = 19'h00000;

  // ---------------------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_POWERUP = 2'b00,
    ST_CLEAR   = 2'b01,
    ST_CONFIG  = 2'b11,
    ST_USER    = 2'b10
  } phase_type;

  localparam logic [7:0] POWERUP_TICKS = 8'h10;
  localparam logic [7:0] CLEAR_TICKS   = 8'h08;

  typedef struct packed {
    logic       primary;
    logic [1:0] taps;
  } user_clk_type;

endpackage : osc_div_pkg

// *** src/onchip_oscillator_divider.sv ***
`timescale 1ns/100ps
module onchip_oscillator_divider
#(
  parameter int HALF_CYCLES = osc_div_pkg::OSC_HALF_CYCLES
)
(
  input  wire logic                      clk_in,
  input  wire logic                      rst_in,
  input  wire logic                      ce_in,
  input  wire logic                      config_done_in,
  input  wire logic                      osc_used_in,
  input  wire logic                      master_mode_in,
  input  wire logic [1:0]                tap_sel_a_in,
  input  wire logic [1:0]                tap_sel_b_in,
  output logic                           config_clock_out,
  output logic                           powerup_done_out,
  output logic                           clear_done_out,
  output logic                           osc_running_out,
  output osc_div_pkg::user_clk_type      user_clk_out
);

  initial
  begin
    if (HALF_CYCLES < 1 || HALF_CYCLES > 65536)
      $error("HALF_CYCLES must lie between one and 65536");
  end

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] done_meta_q;
  logic [1:0] done_sync_q;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      done_meta_q <= 2'h0;
      done_sync_q <= 2'h0;
    end
    else if (ce_in)
    begin
      done_meta_q <= {osc_used_in, config_done_in};
      done_sync_q <= done_meta_q;
    end
  end

  // ---------------------------------------------------------------------------
  // oscillator model
  // ---------------------------------------------------------------------------
  logic [15:0]                     half_cnt_q;
  logic                            osc_q;
  logic                            osc_en;
  logic                            osc_rise;
  osc_div_pkg::phase_type          phase_q;

  // stopped once configured unless the user design keeps it
  assign osc_en = (phase_q != osc_div_pkg::ST_USER) | done_sync_q[1];
  assign osc_rise = osc_en & ~osc_q &
                    (half_cnt_q == 16'(HALF_CYCLES - 1));

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      half_cnt_q <= 16'h0000;
      osc_q      <= 1'b0;
    end
    else if (ce_in && osc_en)
    begin
      if (half_cnt_q == 16'(HALF_CYCLES - 1))
      begin
        half_cnt_q <= 16'h0000;
        osc_q      <= ~osc_q;
      end
      else
        half_cnt_q <= half_cnt_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------------
  // free-running divider
  // ---------------------------------------------------------------------------
  logic [osc_div_pkg::DIV_WIDTH-1:0] div_q;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      div_q <= osc_div_pkg::DIV_RESET;
    else if (ce_in && osc_rise)
      div_q <= div_q + 19'h00001;
  end

  function automatic logic tap_pick(
    input logic [osc_div_pkg::DIV_WIDTH-1:0] d,
    input logic [1:0]                        sel
  );
    case (sel)
      2'h0: tap_pick = d[osc_div_pkg::TAP_BIT0-1];
      2'h1: tap_pick = d[osc_div_pkg::TAP_BIT1-1];
      2'h2: tap_pick = d[osc_div_pkg::TAP_BIT2-1];
      default: tap_pick = d[osc_div_pkg::TAP_BIT3-1];
    endcase
  endfunction : tap_pick

  // ---------------------------------------------------------------------------
  // configuration sequencing
  // ---------------------------------------------------------------------------
  logic [7:0] tick_q;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      phase_q <= osc_div_pkg::ST_POWERUP;
      tick_q  <= 8'h00;
    end
    else if (ce_in)
    begin
      case (phase_q)
        osc_div_pkg::ST_POWERUP:
        begin
          if (osc_rise)
          begin
            if (tick_q == osc_div_pkg::POWERUP_TICKS - 8'h01)
            begin
              phase_q <= osc_div_pkg::ST_CLEAR;
              tick_q  <= 8'h00;
            end
            else
              tick_q <= tick_q + 8'h01;
          end
        end
        osc_div_pkg::ST_CLEAR:
        begin
          if (osc_rise)
          begin
            if (tick_q == osc_div_pkg::CLEAR_TICKS - 8'h01)
            begin
              phase_q <= osc_div_pkg::ST_CONFIG;
              tick_q  <= 8'h00;
            end
            else
              tick_q <= tick_q + 8'h01;
          end
        end
        osc_div_pkg::ST_CONFIG:
        begin
          if (done_sync_q[0])
            phase_q <= osc_div_pkg::ST_USER;
        end
        osc_div_pkg::ST_USER:
          phase_q <= osc_div_pkg::ST_USER;
        default:
          phase_q <= osc_div_pkg::ST_POWERUP;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      config_clock_out <= 1'b0;
      powerup_done_out <= 1'b0;
      clear_done_out   <= 1'b0;
      osc_running_out  <= 1'b0;
    end
    else if (ce_in)
    begin
      config_clock_out <= master_mode_in & osc_q &
                          (phase_q == osc_div_pkg::ST_CONFIG);
      powerup_done_out <= phase_q != osc_div_pkg::ST_POWERUP;
      clear_done_out   <= phase_q == osc_div_pkg::ST_CONFIG ||
                          phase_q == osc_div_pkg::ST_USER;
      osc_running_out  <= osc_en;
    end
  end

  // taps resynchronised on the oscillator edge so user clocks cannot glitch
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      user_clk_out <= '0;
    else if (ce_in)
    begin
      if (phase_q == osc_div_pkg::ST_USER && done_sync_q[1])
      begin
        user_clk_out.primary <= osc_q;
        if (osc_rise)
        begin
          user_clk_out.taps[0] <= tap_pick(div_q, tap_sel_a_in);
          user_clk_out.taps[1] <= tap_pick(div_q, tap_sel_b_in);
        end
      end
      else
        user_clk_out <= '0;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_osc_stops_unused: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (ce_in && phase_q == osc_div_pkg::ST_USER && !done_sync_q[1])
      |=> !osc_running_out)
    else $error("oscillator runs after configuration though unused");

  a_div_counts_up: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (ce_in && osc_rise) |=> div_q == $past(div_q) + 19'h00001)
    else $error("divider failed to advance on oscillator edge");

  a_cfg_clk_gated: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (ce_in && phase_q != osc_div_pkg::ST_CONFIG) |=> !config_clock_out)
    else $error("config clock driven outside configuration");

  a_user_clk_quiet: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (ce_in && phase_q != osc_div_pkg::ST_USER) |=> user_clk_out == '0)
    else $error("user clocks active before configuration");

  a_tap_stable: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (ce_in && !osc_rise && phase_q == osc_div_pkg::ST_USER && done_sync_q[1]
     && $past(phase_q) == osc_div_pkg::ST_USER)
      |=> $stable(user_clk_out.taps))
    else $error("tap changed away from oscillator edge");

  a_osc_period: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $changed(osc_q) |-> half_cnt_q == 16'h0000
      && $past(half_cnt_q) == 16'(HALF_CYCLES - 1))
    else $error("oscillator half period count wrong");

  a_tap_value: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (ce_in && osc_rise && phase_q == osc_div_pkg::ST_USER && done_sync_q[1]
     && tap_sel_a_in == 2'h0)
      |=> user_clk_out.taps[0] == $past(div_q[3]))
    else $error("tap a does not follow divider bit four");

  a_clear_after_pwr: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (phase_q == osc_div_pkg::ST_CLEAR) |-> powerup_done_out
      || $past(phase_q) == osc_div_pkg::ST_POWERUP || !$past(ce_in))
    else $error("clearing began before power-on time-out");

endmodule : onchip_oscillator_divider

// *** verification/test_onchip_oscillator_divider.sv ***
`timescale 1ns/100ps
module test_onchip_oscillator_divider;
  localparam int HALF = 1;
  logic                      clk_in;
  logic                      rst_in;
  logic                      ce_in;
  logic                      config_done_in;
  logic                      osc_used_in;
  logic                      master_mode_in;
  logic [1:0]                tap_sel_a_in;
  logic [1:0]                tap_sel_b_in;
  logic                      config_clock_out;
  logic                      powerup_done_out;
  logic                      clear_done_out;
  logic                      osc_running_out;
  osc_div_pkg::user_clk_type user_clk_out;
  int                        mismatches;
  int                        comparisons;
  int                        cyc;
  int                        last_cyc;
  int                        edges;
  int                        note_q[$];
  logic [1:0]                watch;
  logic                      prev_w;
  logic                      w_sig;

  onchip_oscillator_divider #(.HALF_CYCLES(HALF)) dut_u
  (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .ce_in            (ce_in),
    .config_done_in   (config_done_in),
    .osc_used_in      (osc_used_in),
    .master_mode_in   (master_mode_in),
    .tap_sel_a_in     (tap_sel_a_in),
    .tap_sel_b_in     (tap_sel_b_in),
    .config_clock_out (config_clock_out),
    .powerup_done_out (powerup_done_out),
    .clear_done_out   (clear_done_out),
    .osc_running_out  (osc_running_out),
    .user_clk_out     (user_clk_out)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  assign w_sig = (watch == 2'h2) ? user_clk_out.primary
                                 : user_clk_out.taps[watch[0]];

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  // ---------------------------------------------------------------------
  // output watcher: compares each measured half period with oldest note
  // ---------------------------------------------------------------------
  always @(posedge clk_in) cyc <= cyc + 1;

  always @(negedge clk_in)
  begin
    if (w_sig !== prev_w)
    begin
      edges = edges + 1;
      if (note_q.size() > 0)
        check("half period", cyc - last_cyc, note_q.pop_front());
      last_cyc = cyc;
    end
    prev_w = w_sig;
    if (cyc > 80000)
    begin
      mismatches++;
      results();
    end
  end

  task automatic measure(input logic [1:0] w, input int exp);
    int n;
    @(posedge clk_in);
    watch = w;
    edges = 0;
    n = 0;
    while (edges < 3 && n < 4 * exp + 16)
    begin
      @(posedge clk_in);
      n++;
    end
    note_q.push_back(exp);
    n = 0;
    while (note_q.size() > 0 && n < 2 * exp + 16)
    begin
      @(posedge clk_in);
      n++;
    end
    check("period measured", note_q.size(), 0);
    note_q.delete();
  endtask : measure

  task automatic boot(input logic master, input logic used);
    int   n;
    int   cnt;
    int   pwr;
    int   t_pwr;
    int   t_clr;
    logic prev;
    @(negedge clk_in);
    rst_in = 1'b1;
    config_done_in = 1'b0;
    master_mode_in = master;
    osc_used_in = used;
    repeat (2) @(negedge clk_in);
    check("reset outputs", {config_clock_out, powerup_done_out,
          clear_done_out, osc_running_out, user_clk_out}, 7'h00);
    rst_in = 1'b0;
    n = 0;
    pwr = 0;
    t_pwr = (2 * osc_div_pkg::POWERUP_TICKS - 1) * HALF + 1;
    t_clr = t_pwr + 2 * osc_div_pkg::CLEAR_TICKS * HALF;
    while (clear_done_out !== 1'b1 && n < 200)
    begin
      @(negedge clk_in);
      n++;
      if (powerup_done_out === 1'b1 && pwr == 0)
        pwr = n;
    end
    check("clear done", clear_done_out, 1'b1);
    check("powerup time", pwr, t_pwr);
    check("clear time", n, t_clr);
    check("powerup before clear", powerup_done_out, 1'b1);
    check("osc running", osc_running_out, 1'b1);
    prev = config_clock_out;
    cnt = 0;
    repeat (20)
    begin
      @(negedge clk_in);
      if (config_clock_out !== prev)
        cnt++;
      prev = config_clock_out;
    end
    check("config clock edges", cnt, master ? 20 : 0);
    config_done_in = 1'b1;
    repeat (10) @(negedge clk_in);
    check("osc after config", osc_running_out, used);
    if (!used)
      check("user clocks idle", user_clk_out, 3'h0);
  endtask : boot

  initial
  begin
    int         bits[3];
    logic [2:0] snap;
    bits = '{osc_div_pkg::TAP_BIT0, osc_div_pkg::TAP_BIT1,
             osc_div_pkg::TAP_BIT2};
    mismatches = 0;
    comparisons = 0;
    cyc = 0;
    last_cyc = 0;
    edges = 0;
    watch = 2'h2;
    prev_w = 1'b0;
    rst_in = 1'b1;
    ce_in = 1'b1;
    config_done_in = 1'b0;
    osc_used_in = 1'b0;
    master_mode_in = 1'b0;
    tap_sel_a_in = 2'h0;
    tap_sel_b_in = 2'h1;
    void'($urandom(87687));
    boot(1'b0, 1'b0);
    boot(1'b1, 1'b1);
    measure(2'h2, HALF);
    for (int i = 0; i < 3; i++)
    begin
      @(negedge clk_in);
      tap_sel_a_in = 2'(i);
      measure(2'h0, (1 << (bits[i] - 1)) * 2 * HALF);
    end
    @(negedge clk_in);
    tap_sel_b_in = 2'($urandom % 2);
    measure(2'h1, (1 << (bits[tap_sel_b_in] - 1)) * 2 * HALF);
    @(negedge clk_in);
    ce_in = 1'b0;
    snap = user_clk_out;
    repeat (10) @(negedge clk_in);
    check("frozen clocks", user_clk_out, snap);
    ce_in = 1'b1;
    results();
  end
endmodule : test_onchip_oscillator_divider
